// ===== verilog/msfd_defs.svh
// constants for the special-field decoder: codes, bit positions, offsets
`ifndef MSFD_DEFS_SVH
`define MSFD_DEFS_SVH

// special field codes
`define MSFD_C_CLR_F1 5'h12
`define MSFD_C_CLR_F2 5'h11
`define MSFD_C_CLR_F3 5'h07
`define MSFD_C_SET_F1 5'h13
`define MSFD_C_SET_F2 5'h10
`define MSFD_C_SET_F3 5'h03
`define MSFD_C_ARM_IND 5'h0e
`define MSFD_C_CLR_OVF 5'h19
`define MSFD_C_SET_OVF 5'h18
`define MSFD_C_CLR_SP 5'h02
`define MSFD_C_CRY_F1 5'h06
`define MSFD_C_INC_SP 5'h08
`define MSFD_C_DEC_SP 5'h09
`define MSFD_C_F1_MSB 5'h0d
`define MSFD_C_MSB_F1 5'h0c
`define MSFD_C_LSB_F2 5'h0f
`define MSFD_C_INC_NAME 5'h0a
`define MSFD_C_INC_CNT 5'h0b
`define MSFD_C_POP 5'h17
`define MSFD_C_POP_CC 5'h16
`define MSFD_C_SET_CRY 5'h14
`define MSFD_C_SET_DISP 5'h05
`define MSFD_C_SET_INT 5'h04

// condition code values
`define MSFD_CC_NEG 2'h1
`define MSFD_CC_ZERO 2'h2
`define MSFD_CC_POS 2'h0

// bus bit positions, bit 0 is the msb
`define MSFD_MSB_BIT 0
`define MSFD_LSB_BIT 15
`define MSFD_DISP_BIT 12
`define MSFD_INT_BIT 11

// status register field positions
`define MSFD_ST_F1 0
`define MSFD_ST_F2 1
`define MSFD_ST_F3 2
`define MSFD_ST_IND 3
`define MSFD_ST_OVF 4
`define MSFD_ST_CRY 5
`define MSFD_ST_CC_LO 6
`define MSFD_ST_CC_HI 7

// apb byte offsets
`define MSFD_ADDR_W 12
`define MSFD_OFF_STATUS 12'h000
`define MSFD_OFF_INTSTAT 12'h004
`define MSFD_OFF_STACK 12'h008
`define MSFD_OFF_NAME 12'h00c
`define MSFD_OFF_COUNT 12'h010

// reset values
`define MSFD_RST_BIT 1'h0
`define MSFD_RST_CC 2'h0
`define MSFD_RST_ISTAT 16'h0000
`define MSFD_RST_WORD 32'h00000000

`endif

// ===== verilog/msfd_pkg.sv
// types and decode function of the special-field decoder
`include "msfd_defs.svh"

package msfd_pkg;

	// one decoded action per special field code
	typedef enum {
		MSFD_OP_NONE,
		MSFD_OP_CLR_F1,
		MSFD_OP_CLR_F2,
		MSFD_OP_CLR_F3,
		MSFD_OP_SET_F1,
		MSFD_OP_SET_F2,
		MSFD_OP_SET_F3,
		MSFD_OP_ARM_IND,
		MSFD_OP_CLR_OVF,
		MSFD_OP_SET_OVF,
		MSFD_OP_CLR_SP,
		MSFD_OP_CRY_F1,
		MSFD_OP_INC_SP,
		MSFD_OP_DEC_SP,
		MSFD_OP_F1_MSB,
		MSFD_OP_MSB_F1,
		MSFD_OP_LSB_F2,
		MSFD_OP_INC_NAME,
		MSFD_OP_INC_CNT,
		MSFD_OP_POP,
		MSFD_OP_POP_CC,
		MSFD_OP_SET_CRY,
		MSFD_OP_SET_DISP,
		MSFD_OP_SET_INT
	} msfd_op_t;

	// map a 5-bit code to its action
	function automatic msfd_op_t msfd_decode(input logic [4:0] code);
		case (code)
			`MSFD_C_CLR_F1: return MSFD_OP_CLR_F1;
			`MSFD_C_CLR_F2: return MSFD_OP_CLR_F2;
			`MSFD_C_CLR_F3: return MSFD_OP_CLR_F3;
			`MSFD_C_SET_F1: return MSFD_OP_SET_F1;
			`MSFD_C_SET_F2: return MSFD_OP_SET_F2;
			`MSFD_C_SET_F3: return MSFD_OP_SET_F3;
			`MSFD_C_ARM_IND: return MSFD_OP_ARM_IND;
			`MSFD_C_CLR_OVF: return MSFD_OP_CLR_OVF;
			`MSFD_C_SET_OVF: return MSFD_OP_SET_OVF;
			`MSFD_C_CLR_SP: return MSFD_OP_CLR_SP;
			`MSFD_C_CRY_F1: return MSFD_OP_CRY_F1;
			`MSFD_C_INC_SP: return MSFD_OP_INC_SP;
			`MSFD_C_DEC_SP: return MSFD_OP_DEC_SP;
			`MSFD_C_F1_MSB: return MSFD_OP_F1_MSB;
			`MSFD_C_MSB_F1: return MSFD_OP_MSB_F1;
			`MSFD_C_LSB_F2: return MSFD_OP_LSB_F2;
			`MSFD_C_INC_NAME: return MSFD_OP_INC_NAME;
			`MSFD_C_INC_CNT: return MSFD_OP_INC_CNT;
			`MSFD_C_POP: return MSFD_OP_POP;
			`MSFD_C_POP_CC: return MSFD_OP_POP_CC;
			`MSFD_C_SET_CRY: return MSFD_OP_SET_CRY;
			`MSFD_C_SET_DISP: return MSFD_OP_SET_DISP;
			`MSFD_C_SET_INT: return MSFD_OP_SET_INT;
			default: return MSFD_OP_NONE;
		endcase
	endfunction : msfd_decode

endpackage : msfd_pkg

// ===== verilog/msfd_step_reg.sv
// up/down step register with asynchronous clear
`timescale 1ns/1ps
`include "msfd_defs.svh"

module msfd_step_reg #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk, // cpu clock
	input wire logic rst, // async reset, high
	input wire logic aclr, // async clear, high
	input wire logic inc, // count up this cycle
	input wire logic dec, // count down this cycle
	output logic [WIDTH-1:0] value // current count
);

	logic [WIDTH-1:0] next_value;

	// step by one, increment taking priority
	always_comb begin
		next_value = value;
		if (inc) begin
			next_value = value + WIDTH'(1);
		end else if (dec) begin
			next_value = value - WIDTH'(1);
		end
	end

	// clear wins over any step while aclr stands
	always_ff @(posedge ref_clk or posedge rst or posedge aclr) begin
		if (rst || aclr) begin
			value <= '0;
		end else begin
			value <= next_value;
		end
	end

endmodule : msfd_step_reg

// ===== verilog/msfd_decoder.sv
// special-field decoder of the cpu microinstruction, with apb view
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "msfd_defs.svh"

module msfd_decoder
	import msfd_pkg::*;
#(
	parameter int SP_W = 16,
	parameter int NAME_W = 16,
	parameter int CNT_W = 16
) (
	input wire logic ref_clk, // cpu clock, 200 mhz
	input wire logic rst, // async reset, high
	input wire logic [4:0] special_code, // special field
	input wire logic alu_carry, // alu carry out
	input wire logic [0:15] result_bus_in, // result bus, bit 0 msb
	input wire logic [0:15] test_bus, // test bus word
	input wire logic skip_next, // skip field next option
	input wire logic jump_on_indirect_option, // skip jump option
	output logic result_msb_drive, // drive bus bit 0
	output logic result_msb_value, // value for bus bit 0
	output logic flag_one, // cpu flag one
	output logic flag_two, // cpu flag two
	output logic flag_three, // cpu flag three
	output logic indirect_mask, // masks indirect line
	output logic overflow, // status overflow bit
	output logic carry, // status carry bit
	output logic [1:0] cond_code, // condition code
	output logic [0:15] interrupt_status_reg, // interrupt status
	output logic [SP_W-1:0] stack_pointer_reg, // stack pointer
	output logic [NAME_W-1:0] name_reg, // name register
	output logic [CNT_W-1:0] counter_reg, // counter register
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [`MSFD_ADDR_W-1:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr // apb error
);

	// ======================================================
	// decode
	// ======================================================

	msfd_op_t op;
	logic clear_stack_ptr_op;
	logic increment_stack_ptr_op;
	logic decrement_stack_ptr_op;
	logic increment_name_op;
	logic increment_counter_op;
	logic pop_op;

	// one action per cycle from the held code
	always_comb begin
		op = msfd_decode(special_code);
	end

	// pop forms step the stack pointer down and the name register up at once
	always_comb begin
		pop_op = (op == MSFD_OP_POP) || (op == MSFD_OP_POP_CC);
		clear_stack_ptr_op = (op == MSFD_OP_CLR_SP);
		increment_stack_ptr_op = (op == MSFD_OP_INC_SP);
		decrement_stack_ptr_op = (op == MSFD_OP_DEC_SP) || pop_op;
		increment_name_op = (op == MSFD_OP_INC_NAME) || pop_op;
		increment_counter_op = (op == MSFD_OP_INC_CNT);
	end

	// ======================================================
	// result bus msb drive
	// ======================================================

	// flag one onto bit 0 while the code is held
	always_comb begin
		result_msb_drive = (op == MSFD_OP_F1_MSB);
		result_msb_value = flag_one;
	end

	// ======================================================
	// stack pointer, name and counter registers
	// ======================================================

	// stack pointer: async clear blocks any step while it stands
	msfd_step_reg #(
		.WIDTH(SP_W)
	) u_stack_ptr (
		.ref_clk(ref_clk),
		.rst(rst),
		.aclr(clear_stack_ptr_op),
		.inc(increment_stack_ptr_op),
		.dec(decrement_stack_ptr_op),
		.value(stack_pointer_reg)
	);

	// name register steps up on its own code and on pop
	msfd_step_reg #(
		.WIDTH(NAME_W)
	) u_name (
		.ref_clk(ref_clk),
		.rst(rst),
		.aclr(1'b0),
		.inc(increment_name_op),
		.dec(1'b0),
		.value(name_reg)
	);

	// counter register steps up on its own code only
	msfd_step_reg #(
		.WIDTH(CNT_W)
	) u_counter (
		.ref_clk(ref_clk),
		.rst(rst),
		.aclr(1'b0),
		.inc(increment_counter_op),
		.dec(1'b0),
		.value(counter_reg)
	);

	// ======================================================
	// flags and status bits
	// ======================================================

	logic next_flag_one;
	logic next_flag_two;
	logic next_flag_three;
	logic next_indirect_mask;
	logic next_overflow;
	logic next_carry;
	logic [1:0] next_cond_code;
	logic test_negative;
	logic test_zero;

	// sign and zero of the test bus word
	always_comb begin
		test_negative = test_bus[`MSFD_MSB_BIT];
		test_zero = (test_bus == 16'h0000);
	end

	// next flag values; unlisted codes keep everything
	always_comb begin
		next_flag_one = flag_one;
		next_flag_two = flag_two;
		next_flag_three = flag_three;
		next_overflow = overflow;
		next_carry = carry;
		next_cond_code = cond_code;
		case (op)
			MSFD_OP_CLR_F1: next_flag_one = 1'b0;
			MSFD_OP_CLR_F2: next_flag_two = 1'b0;
			MSFD_OP_CLR_F3: next_flag_three = 1'b0;
			MSFD_OP_SET_F1: next_flag_one = 1'b1;
			MSFD_OP_SET_F2: next_flag_two = 1'b1;
			MSFD_OP_SET_F3: next_flag_three = 1'b1;
			MSFD_OP_CLR_OVF: next_overflow = 1'b0;
			MSFD_OP_SET_OVF: next_overflow = 1'b1;
			MSFD_OP_CRY_F1: next_flag_one = alu_carry;
			MSFD_OP_MSB_F1: begin
				next_flag_one = result_bus_in[`MSFD_MSB_BIT];
			end
			MSFD_OP_LSB_F2: begin
				next_flag_two = result_bus_in[`MSFD_LSB_BIT];
			end
			MSFD_OP_SET_CRY: next_carry = 1'b1;
			MSFD_OP_POP_CC: begin
				if (test_negative) begin
					next_cond_code = `MSFD_CC_NEG;
				end else if (test_zero) begin
					next_cond_code = `MSFD_CC_ZERO;
				end else begin
					next_cond_code = `MSFD_CC_POS;
				end
			end
			default: begin
				next_flag_one = flag_one;
			end
		endcase
	end

	// indirect mask: arming wins over a release in the same cycle
	always_comb begin
		next_indirect_mask = indirect_mask;
		if (skip_next || jump_on_indirect_option) begin
			next_indirect_mask = 1'b0;
		end
		if (op == MSFD_OP_ARM_IND) begin
			next_indirect_mask = 1'b1;
		end
	end

	// register the flags at the end of the microcycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flag_one <= `MSFD_RST_BIT;
			flag_two <= `MSFD_RST_BIT;
			flag_three <= `MSFD_RST_BIT;
			indirect_mask <= `MSFD_RST_BIT;
			overflow <= `MSFD_RST_BIT;
			carry <= `MSFD_RST_BIT;
			cond_code <= `MSFD_RST_CC;
		end else begin
			flag_one <= next_flag_one;
			flag_two <= next_flag_two;
			flag_three <= next_flag_three;
			indirect_mask <= next_indirect_mask;
			overflow <= next_overflow;
			carry <= next_carry;
			cond_code <= next_cond_code;
		end
	end

	// ======================================================
	// interrupt status bits
	// ======================================================

	logic [0:15] next_istat;
	logic istat_write;
	logic [0:15] istat_clear;

	// software clears with ones; a set in the same cycle wins
	always_comb begin
		istat_clear = pwdata[15:0];
		next_istat = interrupt_status_reg;
		if (istat_write) begin
			next_istat = interrupt_status_reg & ~istat_clear;
		end
		if (op == MSFD_OP_SET_DISP) begin
			next_istat[`MSFD_DISP_BIT] = 1'b1;
		end
		if (op == MSFD_OP_SET_INT) begin
			next_istat[`MSFD_INT_BIT] = 1'b1;
		end
	end

	// register the interrupt status word
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			interrupt_status_reg <= `MSFD_RST_ISTAT;
		end else begin
			interrupt_status_reg <= next_istat;
		end
	end

	// ======================================================
	// apb slave
	// ======================================================

	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;
	logic [31:0] read_word;
	logic addr_hit;
	logic access_done;
	logic [7:0] status_byte;

	// status byte as seen by software
	always_comb begin
		status_byte = 8'h00;
		status_byte[`MSFD_ST_F1] = flag_one;
		status_byte[`MSFD_ST_F2] = flag_two;
		status_byte[`MSFD_ST_F3] = flag_three;
		status_byte[`MSFD_ST_IND] = indirect_mask;
		status_byte[`MSFD_ST_OVF] = overflow;
		status_byte[`MSFD_ST_CRY] = carry;
		status_byte[`MSFD_ST_CC_HI:`MSFD_ST_CC_LO] = cond_code;
	end

	// address decode and read mux
	always_comb begin
		addr_hit = 1'b1;
		read_word = `MSFD_RST_WORD;
		case (paddr)
			`MSFD_OFF_STATUS: read_word = 32'(status_byte);
			`MSFD_OFF_INTSTAT: read_word = 32'(interrupt_status_reg);
			`MSFD_OFF_STACK: read_word = 32'(stack_pointer_reg);
			`MSFD_OFF_NAME: read_word = 32'(name_reg);
			`MSFD_OFF_COUNT: read_word = 32'(counter_reg);
			default: addr_hit = 1'b0;
		endcase
	end

	// one wait state; write acts at the edge that sees pready
	always_comb begin
		access_done = psel && penable && pready;
		istat_write = access_done && pwrite &&
			(paddr == `MSFD_OFF_INTSTAT);
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = `MSFD_RST_WORD;
		if (next_pready) begin
			next_pslverr = !addr_hit;
			if (!pwrite) begin
				next_prdata = read_word;
			end
		end
	end

	// register the apb answer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= `MSFD_RST_BIT;
			pslverr <= `MSFD_RST_BIT;
			prdata <= `MSFD_RST_WORD;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

endmodule : msfd_decoder

// ===== testbench/msfd_seq_model.sv
// sequencer model presenting one special field code per microcycle
`timescale 1ns/1ps

module msfd_seq_model (
	input wire logic ref_clk, // cpu clock
	input wire logic rst, // async reset, high
	input wire logic [4:0] next_code, // code queued by the bench
	output logic [4:0] special_code // code held for the cycle
);
	// one code per microcycle, held whole until the next edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			special_code <= 5'h00;
		else
			special_code <= next_code;
	end
endmodule : msfd_seq_model

// ===== testbench/msfd_decoder_properties.sv
// assertions on the special-field decoder ports
`timescale 1ns/1ps
`include "msfd_defs.svh"

module msfd_decoder_properties #(
	parameter int SP_W = 16,
	parameter int NAME_W = 16
) (
	input wire logic ref_clk, // cpu clock
	input wire logic rst, // async reset
	input wire logic [4:0] special_code, // special field
	input wire logic alu_carry, // alu carry
	input wire logic [0:15] test_bus, // test bus word
	input wire logic result_msb_drive, // bus bit 0 enable
	input wire logic result_msb_value, // bus bit 0 value
	input wire logic flag_one, // flag one
	input wire logic flag_two, // flag two
	input wire logic flag_three, // flag three
	input wire logic indirect_mask, // indirect mask
	input wire logic overflow, // overflow bit
	input wire logic carry, // carry bit
	input wire logic [1:0] cond_code, // condition code
	input wire logic [0:15] interrupt_status_reg, // interrupt status
	input wire logic [SP_W-1:0] stack_pointer_reg, // stack pointer
	input wire logic [NAME_W-1:0] name_reg // name register
);
	// ==========================================================
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_pop;
		special_code == `MSFD_C_POP || special_code == `MSFD_C_POP_CC;
	endsequence
	property p_set_f1;
		special_code == `MSFD_C_SET_F1 |=> flag_one;
	endproperty
	a_set_f1: assert property (p_set_f1) else $error("flag one not set");
	property p_clr_f2;
		special_code == `MSFD_C_CLR_F2 |=> !flag_two;
	endproperty
	a_clr_f2: assert property (p_clr_f2) else $error("flag two kept");
	property p_arm;
		special_code == `MSFD_C_ARM_IND |=> indirect_mask;
	endproperty
	a_arm: assert property (p_arm) else $error("mask not armed");
	property p_ovf;
		special_code inside {`MSFD_C_SET_OVF, `MSFD_C_CLR_OVF} |=>
			overflow == $past(special_code == `MSFD_C_SET_OVF);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow wrong");
	property p_clr_sp;
		special_code == `MSFD_C_CLR_SP |-> stack_pointer_reg == '0;
	endproperty
	a_clr_sp: assert property (p_clr_sp) else $error("sp not clear");
	property p_cry_f1;
		special_code == `MSFD_C_CRY_F1 |=> flag_one == $past(alu_carry);
	endproperty
	a_cry_f1: assert property (p_cry_f1) else $error("carry copy");
	property p_inc_sp;
		special_code == `MSFD_C_INC_SP |=> special_code == `MSFD_C_CLR_SP
			|| stack_pointer_reg == $past(stack_pointer_reg) + 1'b1;
	endproperty
	a_inc_sp: assert property (p_inc_sp) else $error("sp step");
	property p_msb;
		result_msb_drive == (special_code == `MSFD_C_F1_MSB)
			&& (!result_msb_drive || result_msb_value == flag_one);
	endproperty
	a_msb: assert property (p_msb) else $error("bus msb drive");
	property p_pop;
		s_pop |=> special_code == `MSFD_C_CLR_SP
			|| (stack_pointer_reg == $past(stack_pointer_reg) - 1'b1
			&& name_reg == $past(name_reg) + 1'b1);
	endproperty
	a_pop: assert property (p_pop) else $error("pop step");
	property p_cc;
		special_code == `MSFD_C_POP_CC |=> cond_code == ($past(test_bus[0])
			? 2'h1 : ($past(test_bus) == 16'h0000 ? 2'h2 : 2'h0));
	endproperty
	a_cc: assert property (p_cc) else $error("cond code");
	property p_none;
		special_code == 5'h00 |=> $stable({flag_one, flag_two, flag_three,
			overflow, carry, cond_code}) && (interrupt_status_reg[11:12]
			& ~$past(interrupt_status_reg[11:12])) == 2'h0;
	endproperty
	a_none: assert property (p_none) else $error("idle changed");
endmodule : msfd_decoder_properties

bind msfd_decoder msfd_decoder_properties #(.SP_W(SP_W), .NAME_W(NAME_W))
	u_props (.ref_clk(ref_clk), .rst(rst), .special_code(special_code),
	.alu_carry(alu_carry), .test_bus(test_bus),
	.result_msb_drive(result_msb_drive),
	.result_msb_value(result_msb_value), .flag_one(flag_one),
	.flag_two(flag_two), .flag_three(flag_three),
	.indirect_mask(indirect_mask), .overflow(overflow), .carry(carry),
	.cond_code(cond_code), .interrupt_status_reg(interrupt_status_reg),
	.stack_pointer_reg(stack_pointer_reg), .name_reg(name_reg));

// ===== testbench/msfd_decoder_bench.sv
// self-checking bench of the special-field decoder
`timescale 1ns/1ps
`include "msfd_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module msfd_decoder_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] nxt = 5'h00, code;
	logic alu_carry = 1'b0, skip_next = 1'b0, jmp = 1'b0;
	logic [0:15] rbus = 16'h0000, tbus = 16'h0000, ist;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, drv, msbv, f1, f2, f3, ind, ovf, cry;
	logic [1:0] cc;
	logic [15:0] sp, nm, cn;
	int err_total = 0, num_checks = 0;

	// ==========================================================
	// clock, sequencer model and design
	always #2.5 ref_clk = ~ref_clk;
	msfd_seq_model seq (.ref_clk(ref_clk), .rst(rst), .next_code(nxt),
		.special_code(code));
	msfd_decoder dut (.ref_clk(ref_clk), .rst(rst), .special_code(code),
		.alu_carry(alu_carry), .result_bus_in(rbus), .test_bus(tbus),
		.skip_next(skip_next), .jump_on_indirect_option(jmp),
		.result_msb_drive(drv), .result_msb_value(msbv), .flag_one(f1),
		.flag_two(f2), .flag_three(f3), .indirect_mask(ind),
		.overflow(ovf), .carry(cry), .cond_code(cc),
		.interrupt_status_reg(ist), .stack_pointer_reg(sp), .name_reg(nm),
		.counter_reg(cn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ==========================================================
	// shared tasks
	task automatic op(input logic [4:0] c);
		@(posedge ref_clk);
		nxt <= c;
	endtask : op
	task automatic run(input logic [4:0] c);
		op(c);
		op(5'h00);
		op(5'h00);
		#1;
	endtask : run
	// apb transfer, waits for ready under a bound
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		// pready is read at the edge, before the flops update
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic finish_test;
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// ==========================================================
	// scenarios
	task automatic t_flags;
		logic [4:0] cs [6] = '{`MSFD_C_SET_F1, `MSFD_C_CLR_F1, `MSFD_C_SET_F2,
			`MSFD_C_CLR_F2, `MSFD_C_SET_F3, `MSFD_C_CLR_F3};
		logic [2:0] ex [6] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};
		for (int i = 0; i < 6; i++) begin
			run(cs[i]);
			`CHK({f1, f2, f3}, ex[i])
		end
		op(`MSFD_C_SET_F1);
		op(`MSFD_C_SET_F2);
		op(`MSFD_C_CLR_F1);
		run(`MSFD_C_SET_F3);
		`CHK({f1, f2, f3}, 3'h3)
	endtask : t_flags
	task automatic t_move;
		@(posedge ref_clk);
		alu_carry <= 1'b1;
		run(`MSFD_C_CRY_F1);
		`CHK(f1, 1'b1)
		@(posedge ref_clk);
		alu_carry <= 1'b0;
		run(`MSFD_C_CRY_F1);
		`CHK(f1, 1'b0)
		@(posedge ref_clk);
		rbus <= 16'h8000;
		run(`MSFD_C_MSB_F1);
		`CHK(f1, 1'b1)
		run(`MSFD_C_LSB_F2);
		`CHK(f2, 1'b0)
		op(`MSFD_C_F1_MSB);
		op(5'h00);
		#1;
		`CHK({drv, msbv}, 2'h3)
	endtask : t_move
	task automatic t_stack;
		op(`MSFD_C_INC_SP);
		op(`MSFD_C_INC_SP);
		op(`MSFD_C_INC_SP);
		op(`MSFD_C_DEC_SP);
		op(`MSFD_C_INC_NAME);
		run(`MSFD_C_INC_CNT);
		`CHK({sp, nm, cn}, {16'h2, 16'h1, 16'h1})
		run(`MSFD_C_POP);
		`CHK({sp, nm}, {16'h1, 16'h2})
		@(posedge ref_clk);
		tbus <= 16'h8000;
		run(`MSFD_C_POP_CC);
		`CHK({sp, nm, cc}, {16'h0, 16'h3, 2'h1})
		@(posedge ref_clk);
		tbus <= 16'h0000;
		run(`MSFD_C_POP_CC);
		`CHK({sp, nm, cc}, {16'hffff, 16'h4, 2'h2})
		@(posedge ref_clk);
		tbus <= 16'h0001;
		run(`MSFD_C_POP_CC);
		`CHK({sp, cc}, {16'hfffe, 2'h0})
		op(`MSFD_C_CLR_SP);
		op(`MSFD_C_INC_SP);
		#1;
		`CHK(sp, 16'h0)
		run(5'h00);
		`CHK(sp, 16'h1)
	endtask : t_stack
	task automatic t_status;
		run(`MSFD_C_SET_OVF);
		`CHK(ovf, 1'b1)
		run(`MSFD_C_CLR_OVF);
		`CHK(ovf, 1'b0)
		run(`MSFD_C_SET_CRY);
		`CHK(cry, 1'b1)
		op(`MSFD_C_SET_DISP);
		run(`MSFD_C_SET_INT);
		`CHK(ist, 16'h0018)
		for (int k = 0; k < 2; k++) begin
			run(`MSFD_C_ARM_IND);
			`CHK(ind, 1'b1)
			@(posedge ref_clk);
			skip_next <= (k == 0);
			jmp <= (k == 1);
			@(posedge ref_clk);
			skip_next <= 1'b0;
			jmp <= 1'b0;
			run(5'h00);
			`CHK(ind, 1'b0)
		end
		apb(1'b0, `MSFD_OFF_INTSTAT, 32'h0);
		`CHK(rd, 32'h18)
		apb(1'b1, `MSFD_OFF_INTSTAT, 32'h8);
		apb(1'b0, `MSFD_OFF_INTSTAT, 32'h0);
		`CHK(rd, 32'h10)
		apb(1'b0, `MSFD_OFF_STATUS, 32'h0);
		`CHK(rd, 32'h25)
		apb(1'b0, 12'h020, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
	endtask : t_status
	task automatic t_none;
		logic [4:0] cs [9] = '{5'h00, 5'h01, 5'h1a, 5'h1b, 5'h1c, 5'h1d,
			5'h1e, 5'h1f, 5'h15};
		logic [71:0] s;
		s = {f1, f2, f3, ind, ovf, cry, cc, sp, nm, cn, ist};
		for (int i = 0; i < 9; i++)
			op(cs[i]);
		run(5'h00);
		`CHK({f1, f2, f3, ind, ovf, cry, cc, sp, nm, cn, ist}, s)
		`CHK(drv, 1'b0)
	endtask : t_none

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, `MSFD_OFF_STATUS, 32'h0);
		`CHK({er, rd}, {1'b0, 32'h0})
		t_flags();
		t_move();
		t_stack();
		t_status();
		t_none();
		finish_test();
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		err_total++;
		finish_test();
	end
endmodule : msfd_decoder_bench
